// file: design/rcm_pkg.sv
// package for the reset and clock mode control block
// assumes one 100 MHz system clock; all other signals are sampled or synchronous
package rcm_pkg;

	// register map (word offsets as byte addresses)
	localparam logic [3:0] SYSCTL2_OFS   = 4'h0; // clock select, oscillator enables, halt
	localparam logic [3:0] TBCTL_OFS     = 4'h4; // time base enable and source select
	localparam logic [3:0] IRQCTL_OFS    = 4'h8; // master enable, time base enable flag
	localparam logic [3:0] TRAPCTL_OFS   = 4'hC; // ram trap enable, trap as interrupt
	localparam logic [3:0] STATUS_OFS    = 4'h0 + 4'h0; // reused below via separate index
	localparam logic [4:0] STAT_OFS      = 5'h10; // read-only status
	localparam logic [4:0] FETCH_OFS     = 5'h14; // fetch address report (write only)

	// field positions of system control register 2
	localparam int HF_EN_BIT   = 7;
	localparam int LF_EN_BIT   = 6;
	localparam int CLK_SEL_BIT = 5;
	localparam int HALT_BIT    = 2;

	// reset values
	localparam logic [7:0] SYSCTL2_RST = 8'hC0; // both oscillators on, fast clock
	localparam logic [3:0] TBCTL_RST   = 4'h0;
	localparam logic [1:0] IRQCTL_RST  = 2'h0;
	localparam logic [1:0] TRAPCTL_RST = 2'h0;
	localparam logic [15:0] RESET_VECTOR = 16'hFFFE;

	// address trap areas
	localparam logic [15:0] SFR_TOP  = 16'h003F;
	localparam logic [15:0] RAM_BASE = 16'h0040;
	localparam logic [15:0] RAM_TOP  = 16'h083F;
	localparam logic [15:0] DBUF_BASE = 16'h0F80;
	localparam logic [15:0] DBUF_TOP  = 16'h0FFF;

	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FC_PERIOD_NS   = 62;   // high-frequency period at 16 MHz, truncated
	localparam int MALF_FC_CYCLES = 24;   // malfunction reset length in fc periods
	localparam int PIN_FC_CYCLES  = 12;   // least external reset low time in fc periods
	localparam int MALF_NS        = MALF_FC_CYCLES * FC_PERIOD_NS;
	localparam int PIN_NS         = PIN_FC_CYCLES * FC_PERIOD_NS;
	localparam logic [7:0] MALF_CYCLES = 8'(MALF_NS / CLK_PERIOD_NS);                  // longest: round down
	localparam logic [7:0] PIN_CYCLES  = 8'((PIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS); // least: round up
	localparam logic [3:0] SYNC_CYCLES = 4'h8; // lf/hf clock alignment delay on switch-back

	// operating modes
	typedef enum logic [2:0] {
		RCM_FAST     = 3'b000,
		RCM_SLOW_SW  = 3'b001,
		RCM_SLOW     = 3'b011,
		RCM_BACK_SW  = 3'b010,
		RCM_HALT     = 3'b110
	} rcm_mode_e;

	// time base / interrupt controls carried together
	typedef struct packed {
		logic       irq_master_enable;
		logic       timebase_irq_enable_flag;
		logic       timebase_timer_enable;
		logic [2:0] timebase_source_select;
	} rcm_tb_s;

endpackage : rcm_pkg

// file: design/rcm_reset_gen.sv
// malfunction and pin reset pulse generator
// assumes requests are synchronous to clk_in; pin level already synchronised
`timescale 1ns/100ps
module rcm_reset_gen
(
	// clock only; no reset
	input  wire logic       clk_in,
	// reset causes
	input  wire logic       pin_low_in,
	input  wire logic       malf_req_in,
	// internal reset
	output logic            sys_reset_out
);
	logic [7:0] pin_count;
	logic [7:0] malf_count;
	logic       pin_held;

	// pin low count; deliberately no reset so it settles from the pin itself
	always_ff @(posedge clk_in)
	begin
		if (!pin_low_in)
			pin_count <= 8'h00;
		else if (pin_count != rcm_pkg::PIN_CYCLES)
			pin_count <= pin_count + 8'h01;
	end

	assign pin_held = (pin_count == rcm_pkg::PIN_CYCLES);

	// malfunction pulse counter, not initialised: may fire once at power-up
	always_ff @(posedge clk_in)
	begin
		if (malf_req_in)
			malf_count <= rcm_pkg::MALF_CYCLES;
		else if (malf_count != 8'h00)
			malf_count <= malf_count - 8'h01;
	end

	// reset follows the held pin until it returns high
	always_ff @(posedge clk_in)
	begin
		sys_reset_out <= pin_held | (malf_count != 8'h00);
	end
endmodule : rcm_reset_gen

// file: design/rcm_top.sv
// reset and clock mode control: halt release, clock switching, reset sources
// assumes an Avalon-MM master on clk_in; pins and oscillator clocks are asynchronous
`timescale 1ns/100ps

// Behaviour
// - timebase edge with irq enabled: release, interrupt
// - timebase edge, irq disabled: release, continue
// - release clears halt bit, restores prior mode
// - release timed by asynchronous clock, may shorten
// - pending watchdog interrupt blocks halt entry
// - clock select one picks low-frequency clock
// - high-frequency enable bit runs that oscillator
// - switch back only after clocks synchronise
// - reset pin ends slow mode, fast restart
// - four sources; malfunction reset max 24 fc
// - malfunction logic uninitialised, spurious power-up pulse
// - reset loads vector, clears enables, latches
// - pin low twelve fc periods applies reset
// - pin high releases reset, vector fetch
// - fetch from sfr, buffer, trapped ram traps
// - trap response configurable reset or interrupt
// - after trap reset, read vector first
// - illegal oscillator shutdown raises clock reset
// - clock reset keeps both oscillators running
module rcm_top
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// pins and asynchronous sources
	input  wire logic        reset_pin_b_in,
	input  wire logic        timebase_clk_in,
	// cpu side events
	input  wire logic        watchdog_irq_in,
	input  wire logic        watchdog_reset_in,
	input  wire logic        fetch_valid_in,
	input  wire logic [15:0] fetch_addr_in,
	// system outputs
	output logic             sys_reset_out,
	output logic [15:0]      reset_vector_out,
	output logic             vector_fetch_out,
	output logic             main_clock_select_out,
	output logic             high_freq_osc_enable_out,
	output logic             low_freq_osc_enable_out,
	output logic             timebase_interrupt_out,
	output logic             trap_interrupt_out,
	output logic             halted_out
);
	// register state
	logic [7:0]          system_control_reg_2;
	rcm_pkg::rcm_tb_s    tb;
	logic                ram_trap_enable;
	logic                trap_as_irq;
	rcm_pkg::rcm_mode_e  mode;
	rcm_pkg::rcm_mode_e  next_mode;
	rcm_pkg::rcm_mode_e  pre_halt_mode;
	logic [3:0]          sync_count;
	// synchronisers
	logic [1:0]          pin_sync;
	logic [2:0]          tb_sync;
	// reset pieces
	logic                int_reset;
	logic                malf_req;
	logic                clk_reset_req;
	logic                trap_hit;
	logic                pin_low;
	logic                was_reset;
	// bus decode
	logic                bus_ack;
	logic                wr_sys;
	logic                wr_tb;
	logic                wr_irq;
	logic                wr_trap;
	logic [31:0]         rd_mux;
	logic [7:0]          wr_val;
	logic [7:0]          sys_written;
	logic                tb_fall;
	logic                release_halt;
	logic                tb_release_irq;
	logic                enter_halt;

	// level synchroniser for reset pin; first stage read only by second
	always_ff @(posedge clk_in)
	begin
		pin_sync <= {pin_sync[0], reset_pin_b_in};
	end

	assign pin_low = ~pin_sync[1];

	// time base clock synchroniser plus edge history stage
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			tb_sync <= 3'h0;
		else
			tb_sync <= {tb_sync[1:0], timebase_clk_in};
	end

	assign tb_fall = tb_sync[2] & ~tb_sync[1]; // time base clock falling edge

	// bus decode: one wait cycle then acknowledge
	assign wr_val  = avs_writedata_in[7:0];
	assign wr_sys  = bus_ack & avs_write_in & (avs_address_in == {1'b0, rcm_pkg::SYSCTL2_OFS});
	assign wr_tb   = bus_ack & avs_write_in & (avs_address_in == {1'b0, rcm_pkg::TBCTL_OFS});
	assign wr_irq  = bus_ack & avs_write_in & (avs_address_in == {1'b0, rcm_pkg::IRQCTL_OFS});
	assign wr_trap = bus_ack & avs_write_in & (avs_address_in == {1'b0, rcm_pkg::TRAPCTL_OFS});

	// illegal oscillator shutdown detection
	assign clk_reset_req = wr_sys &
		((!wr_val[rcm_pkg::HF_EN_BIT] && !wr_val[rcm_pkg::LF_EN_BIT]) ||
		 (!wr_val[rcm_pkg::HF_EN_BIT] && !system_control_reg_2[rcm_pkg::CLK_SEL_BIT]) ||
		 (!wr_val[rcm_pkg::LF_EN_BIT] && system_control_reg_2[rcm_pkg::CLK_SEL_BIT]));

	// illegal write keeps both oscillators on
	assign sys_written = clk_reset_req ?
		(wr_val | (8'h01 << rcm_pkg::HF_EN_BIT) | (8'h01 << rcm_pkg::LF_EN_BIT)) : wr_val;

	// address trap areas
	assign trap_hit = fetch_valid_in &&
		((fetch_addr_in <= rcm_pkg::SFR_TOP) ||
		 (fetch_addr_in >= rcm_pkg::DBUF_BASE && fetch_addr_in <= rcm_pkg::DBUF_TOP) ||
		 (ram_trap_enable && fetch_addr_in >= rcm_pkg::RAM_BASE && fetch_addr_in <= rcm_pkg::RAM_TOP));

	// malfunction causes; trap resets unless set as interrupt; power-up loads one pulse
	assign malf_req = watchdog_reset_in | clk_reset_req | (trap_hit & ~trap_as_irq) | ~rst_b_in;

	// reset pulse generator
	rcm_reset_gen u_reset_gen
	(
		.clk_in        (clk_in),
		.pin_low_in    (pin_low),
		.malf_req_in   (malf_req),
		.sys_reset_out (int_reset)
	);

	// halt release on time base clock falling edge
	assign release_halt   = (mode == rcm_pkg::RCM_HALT) & tb_fall;
	assign tb_release_irq = release_halt & tb.irq_master_enable & tb.timebase_irq_enable_flag &
		tb.timebase_timer_enable;
	// halt request refused while a watchdog interrupt is pending
	assign enter_halt = wr_sys & wr_val[rcm_pkg::HALT_BIT] & ~watchdog_irq_in & ~clk_reset_req;

	// mode sequencing
	always_comb
	begin
		next_mode = mode;
		case (mode)
			rcm_pkg::RCM_FAST:
				if (enter_halt)
					next_mode = rcm_pkg::RCM_HALT;
				else if (system_control_reg_2[rcm_pkg::CLK_SEL_BIT])
					next_mode = rcm_pkg::RCM_SLOW_SW;
			rcm_pkg::RCM_SLOW_SW:
				next_mode = rcm_pkg::RCM_SLOW;
			rcm_pkg::RCM_SLOW:
				if (enter_halt)
					next_mode = rcm_pkg::RCM_HALT;
				else if (!system_control_reg_2[rcm_pkg::CLK_SEL_BIT])
					next_mode = rcm_pkg::RCM_BACK_SW;
			rcm_pkg::RCM_BACK_SW:
				if (sync_count == rcm_pkg::SYNC_CYCLES)
					next_mode = rcm_pkg::RCM_FAST;
			rcm_pkg::RCM_HALT:
				if (release_halt)
					next_mode = pre_halt_mode;
			default:
				next_mode = rcm_pkg::RCM_FAST;
		endcase
	end

	// mode and synchronisation counter; reset lands in fast mode
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || int_reset)
		begin
			mode          <= rcm_pkg::RCM_FAST;
			pre_halt_mode <= rcm_pkg::RCM_FAST;
			sync_count    <= 4'h0;
		end
		else
		begin
			mode <= next_mode;
			if (enter_halt && mode != rcm_pkg::RCM_HALT)
				pre_halt_mode <= mode;
			sync_count <= (mode == rcm_pkg::RCM_BACK_SW) ? sync_count + 4'h1 : 4'h0;
		end
	end

	// control registers; reset clears time base, interrupt and trap enables, sets both oscillator enables
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || int_reset)
		begin
			system_control_reg_2 <= rcm_pkg::SYSCTL2_RST;
			tb                   <= '0;
			ram_trap_enable      <= 1'b0;
			trap_as_irq          <= 1'b0;
		end
		else
		begin
			if (wr_sys)
				system_control_reg_2 <= enter_halt ? sys_written : (sys_written & 8'hFB);
			else if (release_halt)
				system_control_reg_2[rcm_pkg::HALT_BIT] <= 1'b0;
			if (wr_tb)
				tb[3:0] <= {wr_val[3], wr_val[2:0]};
			if (wr_irq)
				tb[5:4] <= wr_val[1:0];
			if (wr_trap)
				{trap_as_irq, ram_trap_enable} <= wr_val[1:0];
		end
	end

	// register readback
	assign rd_mux =
		(avs_address_in == {1'b0, rcm_pkg::SYSCTL2_OFS}) ? {24'h000000, system_control_reg_2} :
		(avs_address_in == {1'b0, rcm_pkg::TBCTL_OFS})   ? {28'h0000000, tb[3:0]} :
		(avs_address_in == {1'b0, rcm_pkg::IRQCTL_OFS})  ? {30'h00000000, tb[5:4]} :
		(avs_address_in == {1'b0, rcm_pkg::TRAPCTL_OFS}) ? {30'h00000000, trap_as_irq, ram_trap_enable} :
		(avs_address_in == rcm_pkg::STAT_OFS)            ? {29'h00000000, mode} :
		32'h00000000;

	// bus handshake: waitrequest high until the acknowledge cycle
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			bus_ack             <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h00000000;
		end
		else
		begin
			bus_ack             <= (avs_read_in | avs_write_in) & ~bus_ack;
			avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~bus_ack); // registered inverse of ack
			avs_readdata_out    <= rd_mux;
		end
	end

	// outputs and vector fetch after any reset
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			sys_reset_out            <= 1'b1;
			was_reset                <= 1'b1;
			vector_fetch_out         <= 1'b0;
			reset_vector_out         <= rcm_pkg::RESET_VECTOR;
			main_clock_select_out    <= 1'b0;
			high_freq_osc_enable_out <= 1'b1;
			low_freq_osc_enable_out  <= 1'b1;
			timebase_interrupt_out   <= 1'b0;
			trap_interrupt_out       <= 1'b0;
			halted_out               <= 1'b0;
		end
		else
		begin
			sys_reset_out            <= int_reset;
			was_reset                <= int_reset;
			vector_fetch_out         <= was_reset & ~int_reset;
			reset_vector_out         <= rcm_pkg::RESET_VECTOR;
			main_clock_select_out    <= (mode == rcm_pkg::RCM_SLOW) || (mode == rcm_pkg::RCM_BACK_SW) ||
				(mode == rcm_pkg::RCM_HALT && pre_halt_mode != rcm_pkg::RCM_FAST);
			high_freq_osc_enable_out <= system_control_reg_2[rcm_pkg::HF_EN_BIT];
			low_freq_osc_enable_out  <= system_control_reg_2[rcm_pkg::LF_EN_BIT];
			timebase_interrupt_out   <= tb_release_irq;
			trap_interrupt_out       <= trap_hit & trap_as_irq;
			halted_out               <= (next_mode == rcm_pkg::RCM_HALT);
		end
	end
endmodule : rcm_top

// file: tb/rcm_ext_src.sv
// far side model: external reset source and time base clock source
// assumes the caller gives hold lengths in system clock cycles
`timescale 1ns/100ps
module rcm_ext_src
(
	// clock
	input  wire logic clk_in,
	// pins
	output logic      reset_pin_b_out,
	output logic      timebase_clk_out
);
	// pin pulled up, time base stands high between ticks
	initial
	begin
		reset_pin_b_out = 1'b1;
		timebase_clk_out = 1'b1;
	end

	// hold pin low for n cycles, off the clock edge
	task pin_low(input int n);
		@(posedge clk_in);
		#2 reset_pin_b_out = 1'b0;
		repeat (n) @(posedge clk_in);
		#2 reset_pin_b_out = 1'b1;
	endtask : pin_low

	// one asynchronous falling edge of the time base source
	task tick;
		#3 timebase_clk_out = 1'b0;
		repeat (4) @(posedge clk_in);
		#3 timebase_clk_out = 1'b1;
	endtask : tick
endmodule : rcm_ext_src

// file: tb/rcm_top_sva.sv
// checker for the reset and clock mode block, ports only
// assumes one clock domain and the synchronous active low reset
`timescale 1ns/100ps
module rcm_top_sva
(
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic [4:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic        avs_waitrequest_out,
	input wire logic        reset_pin_b_in,
	input wire logic        watchdog_irq_in,
	input wire logic        fetch_valid_in,
	input wire logic [15:0] fetch_addr_in,
	input wire logic        sys_reset_out,
	input wire logic [15:0] reset_vector_out,
	input wire logic        vector_fetch_out,
	input wire logic        main_clock_select_out,
	input wire logic        high_freq_osc_enable_out,
	input wire logic        low_freq_osc_enable_out,
	input wire logic        timebase_interrupt_out,
	input wire logic        trap_interrupt_out,
	input wire logic        halted_out
);
	logic [7:0] rcnt;
	logic [7:0] plow;
	wire        wr0 = avs_write_in && !avs_waitrequest_out && avs_address_in == 5'h00 && !sys_reset_out;
	wire        bad = (!avs_writedata_in[7] && high_freq_osc_enable_out && !main_clock_select_out)
		|| (!avs_writedata_in[6] && low_freq_osc_enable_out && main_clock_select_out);

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// length of reset with pin high, and of pin low
	always_ff @(posedge clk_in)
	begin
		rcnt <= (!rst_b_in || !sys_reset_out || !reset_pin_b_in) ? 8'h00 : rcnt + 8'(rcnt != 8'hFF);
		plow <= (!rst_b_in || reset_pin_b_in) ? 8'h00 : plow + 8'(plow != 8'hFF);
	end

	a_wait_one: assert property (($rose(avs_read_in) || $rose(avs_write_in)) |=> !avs_waitrequest_out)
		else $error("no answer one cycle after request");
	a_sel_slow: assert property (wr0 && avs_writedata_in[6:5] == 2'b11 |-> ##[1:4] main_clock_select_out)
		else $error("low clock not selected");
	a_sel_sync: assert property (wr0 && avs_writedata_in[7] && !avs_writedata_in[5] && main_clock_select_out
		&& high_freq_osc_enable_out |=> main_clock_select_out [*6] ##[1:6] !main_clock_select_out)
		else $error("switch back timing wrong");
	a_hf_off: assert property (wr0 && main_clock_select_out && avs_writedata_in[7:5] == 3'b011
		|-> ##[1:3] !high_freq_osc_enable_out)
		else $error("fast oscillator not stopped");
	a_clk_rst: assert property (wr0 && bad |-> ##[1:4] sys_reset_out)
		else $error("no clock reset on illegal stop");
	a_osc_kept: assert property (wr0 && bad && high_freq_osc_enable_out && low_freq_osc_enable_out
		|=> (high_freq_osc_enable_out && low_freq_osc_enable_out) [*4])
		else $error("oscillator stopped by illegal write");
	a_rst_bound: assert property (rcnt <= 8'd160)
		else $error("malfunction reset too long");
	a_pin_apply: assert property (plow == 8'd80 |-> sys_reset_out)
		else $error("held pin gave no reset");
	a_vec_fetch: assert property ($fell(sys_reset_out) |-> ##[0:1] vector_fetch_out)
		else $error("no vector fetch after reset");
	a_vec_const: assert property ($past(rst_b_in) |-> reset_vector_out == rcm_pkg::RESET_VECTOR)
		else $error("reset vector wrong");
	a_halt_block: assert property (wr0 && watchdog_irq_in && avs_writedata_in[2] |=> !halted_out [*2])
		else $error("halt entered with watchdog pending");
	a_irq_release: assert property ($rose(timebase_interrupt_out) |-> $past(halted_out) || $past(halted_out, 2))
		else $error("time base interrupt without release");
	a_trap_fetch: assert property (fetch_valid_in && fetch_addr_in <= rcm_pkg::SFR_TOP && !sys_reset_out
		|-> ##[1:4] (sys_reset_out || trap_interrupt_out))
		else $error("sfr fetch not trapped");
endmodule : rcm_top_sva

bind rcm_top rcm_top_sva u_sva
(
	.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_waitrequest_out(avs_waitrequest_out), .reset_pin_b_in(reset_pin_b_in),
	.watchdog_irq_in(watchdog_irq_in), .fetch_valid_in(fetch_valid_in), .fetch_addr_in(fetch_addr_in),
	.sys_reset_out(sys_reset_out), .reset_vector_out(reset_vector_out), .vector_fetch_out(vector_fetch_out),
	.main_clock_select_out(main_clock_select_out), .high_freq_osc_enable_out(high_freq_osc_enable_out),
	.low_freq_osc_enable_out(low_freq_osc_enable_out), .timebase_interrupt_out(timebase_interrupt_out),
	.trap_interrupt_out(trap_interrupt_out), .halted_out(halted_out)
);

// file: tb/rcm_top_tb.sv
// self-checking bench for the reset and clock mode block
// assumes the far side model drives the reset pin and time base clock
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module rcm_top_tb;
	localparam logic [4:0] A_SYS = 5'h00;
	localparam logic [4:0] A_TB  = 5'h04;
	localparam logic [4:0] A_IRQ = 5'h08;
	localparam logic [4:0] A_TRP = 5'h0C;
	logic clk_in = 0, rst_b_in = 0, avs_read_in = 0, avs_write_in = 0, watchdog_irq_in = 0;
	logic watchdog_reset_in = 0, fetch_valid_in = 0, reset_pin_b_in, timebase_clk_in, prev_rst = 0;
	logic [4:0]  avs_address_in = 0;
	logic [31:0] avs_writedata_in = 0, avs_readdata_out, rdv;
	logic [15:0] fetch_addr_in = 0, reset_vector_out;
	logic sys_reset_out, vector_fetch_out, main_clock_select_out, high_freq_osc_enable_out;
	logic low_freq_osc_enable_out, timebase_interrupt_out, trap_interrupt_out, halted_out, avs_waitrequest_out;
	logic [7:0] bad_t [3] = '{8'h00, 8'h40, 8'hA0};
	int mismatches = 0, check_count = 0, irq_n = 0, trap_n = 0, rst_n = 0, vf_n = 0, k, c;
	int seed = 32'ha6ad;

	rcm_top u_dut
	(
		.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .reset_pin_b_in(reset_pin_b_in),
		.timebase_clk_in(timebase_clk_in), .watchdog_irq_in(watchdog_irq_in),
		.watchdog_reset_in(watchdog_reset_in), .fetch_valid_in(fetch_valid_in), .fetch_addr_in(fetch_addr_in),
		.sys_reset_out(sys_reset_out), .reset_vector_out(reset_vector_out), .vector_fetch_out(vector_fetch_out),
		.main_clock_select_out(main_clock_select_out), .high_freq_osc_enable_out(high_freq_osc_enable_out),
		.low_freq_osc_enable_out(low_freq_osc_enable_out), .timebase_interrupt_out(timebase_interrupt_out),
		.trap_interrupt_out(trap_interrupt_out), .halted_out(halted_out)
	);
	rcm_ext_src u_ext (.clk_in(clk_in), .reset_pin_b_out(reset_pin_b_in), .timebase_clk_out(timebase_clk_in));

	// clock and event counters
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		irq_n += (timebase_interrupt_out === 1'b1);
		trap_n += (trap_interrupt_out === 1'b1);
		vf_n += (vector_fetch_out === 1'b1);
		rst_n += (sys_reset_out === 1'b1 && !prev_rst);
		prev_rst = (sys_reset_out === 1'b1);
	end

	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	// one avalon transfer, held until waitrequest is seen low
	task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= d;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0); // hang guard ends a lost answer
		rdv = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : xfer

	// illegal oscillator stop, from the written byte and the select in force
	function automatic logic illegal_stop(input logic [7:0] v, input logic sel);
		return (!v[rcm_pkg::HF_EN_BIT] && !v[rcm_pkg::LF_EN_BIT]) || (!v[rcm_pkg::HF_EN_BIT] && !sel) ||
			(!v[rcm_pkg::LF_EN_BIT] && sel);
	endfunction : illegal_stop

	// wait out an internal reset, bounded
	task wait_ok;
		int n;
		n = 0;
		while (sys_reset_out !== 1'b0 && ++n < 400) @(posedge clk_in);
		if (n >= 400) mismatches++;
		cyc(3);
	endtask : wait_ok

	task fetch(input logic [15:0] a);
		@(posedge clk_in);
		fetch_valid_in <= 1'b1;
		fetch_addr_in <= a;
		@(posedge clk_in);
		fetch_valid_in <= 1'b0;
		cyc(6);
	endtask : fetch

	task end_test(input string s);
		$display("test %s done, %0d mismatches", s, mismatches);
	endtask : end_test

	task finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// hang guard
	initial
	begin
		#400000;
		mismatches++;
		finish_test();
	end

	// main sequence
	initial
	begin
		cyc(5);
		rst_b_in <= 1'b1;
		wait_ok();
		xfer(0, A_SYS, 0); `CHK("sysctl2", 32'h000000C0, rdv)
		xfer(0, A_IRQ, 0); `CHK("irqctl", 32'h0, rdv)
		xfer(1, 5'h18, 32'hFF);
		xfer(0, 5'h18, 0); `CHK("unmapped", 32'h0, rdv)
		end_test("registers");
		xfer(1, A_SYS, 32'hE0); cyc(4); `CHK("sel slow", 1'b1, main_clock_select_out)
		xfer(1, A_SYS, 32'h60); cyc(4); `CHK("hf off", 1'b0, high_freq_osc_enable_out)
		xfer(1, A_SYS, 32'hE0); cyc(24); `CHK("hf on", 1'b1, high_freq_osc_enable_out)
		xfer(1, A_SYS, 32'hC0); cyc(3); `CHK("sel held", 1'b1, main_clock_select_out)
		cyc(10); `CHK("sel fast", 1'b0, main_clock_select_out)
		end_test("clock switch");
		for (int i = 0; i < 3; i++)
		begin
			xfer(1, A_SYS, (i == 2) ? 32'hE0 : 32'hC0);
			cyc(15);
			k = rst_n;
			xfer(1, A_SYS, {24'h0, bad_t[i]});
			cyc(6);
			`CHK("clock reset", illegal_stop(bad_t[i], i == 2), rst_n > k)
			`CHK("osc kept", 2'b11, {high_freq_osc_enable_out, low_freq_osc_enable_out})
			wait_ok();
		end
		end_test("illegal stop");
		xfer(1, A_SYS, 32'hE0); cyc(5);
		k = rst_n; u_ext.pin_low(8); cyc(10); `CHK("glitch", k, rst_n)
		k = vf_n; u_ext.pin_low(90); `CHK("pin reset", 1'b1, sys_reset_out)
		wait_ok(); `CHK("vector fetch", k + 1, vf_n)
		`CHK("vector", rcm_pkg::RESET_VECTOR, reset_vector_out)
		`CHK("fast after pin", 1'b0, main_clock_select_out)
		end_test("reset pin");
		for (int i = 0; i < 2; i++)
		begin
			xfer(1, A_IRQ, (i == 0) ? 32'h3 : 32'h0);
			xfer(1, A_TB, 32'h8 | (32'($random(seed)) & 32'h7));
			xfer(1, A_SYS, 32'hC4); cyc(3); `CHK("halted", 1'b1, halted_out)
			k = irq_n; u_ext.tick(); cyc(8);
			`CHK("released", 1'b0, halted_out)
			`CHK("tb irq", k + ((i == 0) ? 1 : 0), irq_n)
			xfer(0, A_SYS, 0); `CHK("halt bit", 32'h000000C0, rdv)
		end
		end_test("halt release");
		watchdog_irq_in <= 1'b1;
		xfer(1, A_SYS, 32'hC4); cyc(3); `CHK("no halt", 1'b0, halted_out)
		watchdog_irq_in <= 1'b0;
		watchdog_reset_in <= 1'b1; @(posedge clk_in); watchdog_reset_in <= 1'b0;
		cyc(4); `CHK("wdt reset", 1'b1, sys_reset_out)
		c = 0;
		while (sys_reset_out === 1'b1 && ++c < 400) @(posedge clk_in);
		`CHK("reset short", 1'b1, c <= 148)
		cyc(3);
		end_test("watchdog");
		k = rst_n;
		for (int i = 0; i < 16; i++) fetch(16'h1000 + (16'($random(seed)) & 16'h3FFF));
		fetch(rcm_pkg::RAM_BASE); `CHK("no trap", k, rst_n)
		xfer(1, A_TRP, 32'h2); k = trap_n; fetch(16'h0010);
		`CHK("trap irq", k + 1, trap_n)
		`CHK("trap no reset", 1'b0, sys_reset_out)
		xfer(1, A_TRP, 32'h1); k = vf_n; fetch(rcm_pkg::RAM_BASE);
		`CHK("ram trap", 1'b1, sys_reset_out)
		wait_ok(); `CHK("trap vector", k + 1, vf_n)
		fetch(rcm_pkg::DBUF_BASE); `CHK("buffer trap", 1'b1, sys_reset_out)
		wait_ok();
		end_test("address trap");
		finish_test();
	end
endmodule : rcm_top_tb
